//--- pft_pkg.sv
// pft_pkg: constants, fault types and register map of the pilot fault trip block
package pft_pkg;
	typedef enum logic [3:0] {
		FT_NONE, FT_AG, FT_BG, FT_CG, FT_AB, FT_BC, FT_CA,
		FT_ABG, FT_BCG, FT_CAG, FT_3P, FT_UNREC
	} pft_fault_t;

	typedef enum logic [1:0] {
		CW_ONE = 2'h0,
		CW_TWO = 2'h1,
		CW_FOUR = 2'h2
	} pft_width_t;

	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned F3P_TIME_MS = 8;
	localparam int unsigned F3P_CYCLES_DEF = F3P_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned F3P_CNT_W = 20;

	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_CHAN = 12'h008;

	localparam int unsigned CTRL_MODE_BIT = 0;
	localparam int unsigned CTRL_WIDTH_LSB = 1;
	localparam int unsigned CTRL_PILOT_EN_BIT = 3;
	localparam int unsigned CTRL_SPT_EN_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h18;

	localparam logic [1:0] TX2_GRP_A = 2'h1;
	localparam logic [1:0] TX2_GRP_B = 2'h2;
	localparam logic [1:0] TX2_GRP_C = 2'h3;
	localparam logic [3:0] TX4_AG = 4'h1;
	localparam logic [3:0] TX4_BG = 4'h2;
	localparam logic [3:0] TX4_CG = 4'h4;
	localparam logic [3:0] TX4_MP = 4'h8;
	localparam logic [3:0] TX_ZERO = 4'h0;
endpackage

//--- pft_coder_if.sv
// pft_coder_if: carrier between the trip core and the pilot scheme coder
`timescale 1ns/1ps
`default_nettype none
interface pft_coder_if;
	import pft_pkg::*;
	pft_fault_t fault_type;
	logic force_3p;
	logic blocking_mode;
	pft_width_t width;
	logic [3:0] rx_bits;
	logic [3:0] tx_bits;
	logic act_a;
	logic act_b;
	logic act_c;
	logic act_3p;

	modport core (output fault_type, force_3p, blocking_mode, width, rx_bits,
		input tx_bits, act_a, act_b, act_c, act_3p);
	modport coder (input fault_type, force_3p, blocking_mode, width, rx_bits,
		output tx_bits, act_a, act_b, act_c, act_3p);
endinterface
`default_nettype wire

//--- pft_coder.sv
// pft_coder: pilot scheme transmit coding and local/remote trip combining
`timescale 1ns/1ps
`default_nettype none
module pft_coder
	import pft_pkg::*;
(
	pft_coder_if.coder cif
);
	logic ground_a, ground_b, ground_c, multi, local_fault, grp_a, grp_b;
	logic [3:0] perm_tx, rx_perm;
	logic remote_valid, remote_fault;

	always_comb begin
		ground_a = (cif.fault_type == FT_AG) && !cif.force_3p;
		ground_b = (cif.fault_type == FT_BG) && !cif.force_3p;
		ground_c = (cif.fault_type == FT_CG) && !cif.force_3p;
		// multi-phase, unrecognized or forced three pole all set multi; unless forced, the two-bit code still sends BC, BCG as group A and CA, CAG as group B
		multi = cif.force_3p || (cif.fault_type != FT_NONE && !ground_a && !ground_b && !ground_c);
		local_fault = ground_a || ground_b || ground_c || multi;
		grp_a = cif.fault_type inside {FT_AG, FT_BC, FT_BCG};
		grp_b = cif.fault_type inside {FT_BG, FT_CA, FT_CAG};
	end

	// permissive code; blocking sends its inverse
	always_comb begin
		perm_tx = TX_ZERO;
		case (cif.width)
			CW_ONE: perm_tx = {3'h0, local_fault};
			CW_TWO: begin
				if (!local_fault)
					perm_tx = TX_ZERO;
				else if (grp_a && !cif.force_3p)
					perm_tx = {2'h0, TX2_GRP_A};
				else if (grp_b && !cif.force_3p)
					perm_tx = {2'h0, TX2_GRP_B};
				else
					perm_tx = {2'h0, TX2_GRP_C};
			end
			CW_FOUR: begin
				if (ground_a)
					perm_tx = TX4_AG;
				else if (ground_b)
					perm_tx = TX4_BG;
				else if (ground_c)
					perm_tx = TX4_CG;
				else if (multi)
					perm_tx = TX4_MP;
				else
					perm_tx = TX_ZERO;
			end
			default: perm_tx = TX_ZERO;
		endcase
	end

	always_comb begin
		case (cif.width)
			CW_ONE: cif.tx_bits = cif.blocking_mode ? {3'h0, ~perm_tx[0]} : perm_tx;
			CW_TWO: cif.tx_bits = cif.blocking_mode ? {2'h0, ~perm_tx[1:0]} : perm_tx;
			default: cif.tx_bits = cif.blocking_mode ? ~perm_tx : perm_tx;
		endcase
	end

	// received bits brought to permissive sense, then checked for a legal code
	always_comb begin
		rx_perm = TX_ZERO;
		remote_valid = 1'b0;
		case (cif.width)
			CW_ONE: begin
				rx_perm = {3'h0, cif.blocking_mode ? ~cif.rx_bits[0] : cif.rx_bits[0]};
				remote_valid = 1'b1;
			end
			CW_TWO: begin
				rx_perm = {2'h0, cif.blocking_mode ? ~cif.rx_bits[1:0] : cif.rx_bits[1:0]};
				remote_valid = 1'b1;
			end
			CW_FOUR: begin
				rx_perm = cif.blocking_mode ? ~cif.rx_bits : cif.rx_bits;
				remote_valid = $onehot0(rx_perm);
			end
			default: begin
				rx_perm = TX_ZERO;
				remote_valid = 1'b0;
			end
		endcase
		remote_fault = remote_valid && (rx_perm != TX_ZERO);
	end

	always_comb begin
		cif.act_a = remote_fault && ground_a;
		cif.act_b = remote_fault && ground_b;
		cif.act_c = remote_fault && ground_c;
		cif.act_3p = remote_fault && multi;
	end
endmodule // pft_coder
`default_nettype wire

//--- pft_trip.sv
// pft_trip: phase selector gating, trip output decision, forced three pole timer and register slave
//
// Operation
// - multi-phase fault at trip request trips all three poles together.
// - pole-open activation follows only the single-pole trip, never a three-pole trip.
// - reclose in progress keeps the phase selector blocked with no outputs.
// - after a single-pole trip, no new trip until force three pole asserts.
// - trip requests during force three pole become three-pole trips.
// - a three-pole trip clears the single-pole trip and so the pole-open activation.
// - selector captures pre-fault values and evaluates only when disturbance detector operates; the code holds no pre-fault values.
// - any trip or reclose clears selector outputs and ignores disturbance detector.
// - unknown current classification falls back to voltage classification.
// - multi-bit channels ignore invalid received codes.
// - channel width setting of one, two or four bits selects codes and combining.
// - permissive one-bit: transmit bit 1 high for any fault or force.
// - blocking one-bit: transmit bit 1 low for any fault, high otherwise; the code also sends it low under force three pole.
// - permissive one-bit with receive high trips faulted phase or all three.
// - blocking one-bit with receive low trips faulted phase or all three.
// - unrecognized fault or force three pole gives a three-phase trip output.
// - force three pole asserts 8 ms after reclose starts, enabling pending trips.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pft_trip
	import pft_pkg::*;
#(
	parameter int unsigned FORCE_3P_CYCLES = F3P_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic disturbance_detector_i,
	input wire logic [3:0] current_class_i,
	input wire logic [3:0] voltage_class_i,
	input wire logic reclose_in_progress_i,
	input wire logic local_trip_request_i,
	input wire logic [3:0] receive_bits_i,
	output logic [3:0] transmit_bits_o,
	output logic [3:0] fault_type_o,
	output logic trip_a_o,
	output logic trip_b_o,
	output logic trip_c_o,
	output logic trip_single_pole_o,
	output logic trip_three_pole_o,
	output logic pole_open_start_o,
	output logic force_three_pole_o
);
	pft_coder_if cif ();

	logic [4:0] ctrl_q;
	pft_fault_t sel_q, sel_d;
	logic eval_q;
	logic trip_1p_q, trip_3p_q;
	logic [2:0] pole_q;
	logic lockout_q;
	logic force_q, timer_run_q, rip_q;
	logic [F3P_CNT_W-1:0] timer_q;
	logic [3:0] tx_q;
	logic [31:0] rdata_q;
	logic ready_q, err_q;
	logic sel_block, trip_req, multi_sel, go_three, any_trip;
	logic setup, wr_en, addr_ok;
	pft_fault_t cur_cls, volt_cls;

	localparam logic [F3P_CNT_W-1:0] F3P_LAST = F3P_CNT_W'(FORCE_3P_CYCLES - 1);

	pft_coder u_coder (
		.cif(cif)
	);

	assign cif.fault_type = sel_q;
	assign cif.force_3p = force_q;
	assign cif.blocking_mode = ctrl_q[CTRL_MODE_BIT];
	assign cif.width = pft_width_t'(ctrl_q[CTRL_WIDTH_LSB +: 2]);
	assign cif.rx_bits = receive_bits_i;

	// phase selector
	assign any_trip = trip_1p_q || trip_3p_q;
	assign sel_block = any_trip || reclose_in_progress_i;
	assign cur_cls = pft_fault_t'(current_class_i);
	assign volt_cls = pft_fault_t'(voltage_class_i);

	always_comb begin
		sel_d = FT_UNREC;
		if (cur_cls inside {[FT_AG:FT_3P]})
			sel_d = cur_cls;
		else if (volt_cls inside {[FT_AG:FT_3P]})
			sel_d = volt_cls;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			eval_q <= 1'b0;
			sel_q <= FT_NONE;
		end else if (sel_block) begin
			eval_q <= 1'b0;
			sel_q <= FT_NONE;
		end else if (disturbance_detector_i || eval_q) begin
			eval_q <= 1'b1;
			sel_q <= sel_d;
		end else begin
			sel_q <= FT_NONE;
		end
	end

	// trip output decision
	assign trip_req = local_trip_request_i
		|| (ctrl_q[CTRL_PILOT_EN_BIT] && (cif.act_a || cif.act_b || cif.act_c || cif.act_3p));
	assign multi_sel = !(sel_q inside {FT_AG, FT_BG, FT_CG});
	assign go_three = force_q || multi_sel || !ctrl_q[CTRL_SPT_EN_BIT] || cif.act_3p;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			trip_1p_q <= 1'b0;
			trip_3p_q <= 1'b0;
			pole_q <= 3'h0;
		end else if (!trip_req) begin
			trip_1p_q <= 1'b0;
			trip_3p_q <= 1'b0;
			pole_q <= 3'h0;
		end else if (!lockout_q && go_three && !trip_3p_q) begin
			trip_3p_q <= 1'b1;
			trip_1p_q <= 1'b0;
			pole_q <= 3'h7;
		end else if (!lockout_q && !any_trip) begin
			trip_1p_q <= 1'b1;
			pole_q <= {sel_q == FT_CG, sel_q == FT_BG, sel_q == FT_AG};
		end
	end

	// after a single pole trip, hold off until the forced three pole window opens
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			lockout_q <= 1'b0;
		else if (force_q)
			lockout_q <= 1'b0;
		else if (trip_1p_q)
			lockout_q <= 1'b1;
	end

	// forced three pole timer, started with the reclose initiation by the first trip
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rip_q <= 1'b0;
			timer_run_q <= 1'b0;
			timer_q <= '0;
			force_q <= 1'b0;
		end else begin
			rip_q <= reclose_in_progress_i;
			if (rip_q && !reclose_in_progress_i) begin
				timer_run_q <= 1'b0;
				timer_q <= '0;
				force_q <= 1'b0;
			end else if (timer_run_q) begin
				if (timer_q == F3P_LAST) begin
					timer_run_q <= 1'b0;
					force_q <= 1'b1;
				end else begin
					timer_q <= timer_q + 1'b1;
				end
			end else if (any_trip && !force_q) begin
				timer_run_q <= 1'b1;
				timer_q <= '0;
			end
		end
	end

	// registered outputs
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_q <= TX_ZERO;
			trip_a_o <= 1'b0;
			trip_b_o <= 1'b0;
			trip_c_o <= 1'b0;
			trip_single_pole_o <= 1'b0;
			trip_three_pole_o <= 1'b0;
			pole_open_start_o <= 1'b0;
			force_three_pole_o <= 1'b0;
			fault_type_o <= 4'h0;
		end else begin
			tx_q <= cif.tx_bits;
			trip_a_o <= pole_q[0];
			trip_b_o <= pole_q[1];
			trip_c_o <= pole_q[2];
			trip_single_pole_o <= trip_1p_q;
			trip_three_pole_o <= trip_3p_q;
			pole_open_start_o <= trip_1p_q && !trip_3p_q;
			force_three_pole_o <= force_q;
			fault_type_o <= sel_q;
		end
	end
	assign transmit_bits_o = tx_q;

	// APB slave, one wait-free access phase
	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pready_o && pwrite_i && paddr_i == REG_CTRL;
	assign addr_ok = paddr_i inside {REG_CTRL, REG_STATUS, REG_CHAN};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			ctrl_q <= CTRL_RESET;
		else if (wr_en)
			ctrl_q <= pwdata_i[4:0];
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ready_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0;
		end else begin
			ready_q <= setup;
			err_q <= setup && (!addr_ok || (pwrite_i && paddr_i != REG_CTRL));
			if (setup && !pwrite_i) begin
				case (paddr_i)
					REG_CTRL: rdata_q <= {27'h0, ctrl_q};
					REG_STATUS: rdata_q <= {20'h0, sel_q, lockout_q, force_q, trip_3p_q, trip_1p_q,
						pole_q, eval_q};
					REG_CHAN: rdata_q <= {24'h0, tx_q, receive_bits_i};
					default: rdata_q <= 32'h0;
				endcase
			end else if (setup) begin
				rdata_q <= 32'h0;
			end
		end
	end
	assign prdata_o = rdata_q;
	assign pready_o = ready_q;
	assign pslverr_o = err_q;
endmodule // pft_trip
`default_nettype wire

//--- pft_trip_monitor.sv
// pft_trip_monitor: port-level assertions for the trip block
`timescale 1ns/1ps
`default_nettype none
module pft_trip_monitor (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic reclose_in_progress_i,
	input wire logic [3:0] fault_type_o,
	input wire logic trip_a_o,
	input wire logic trip_b_o,
	input wire logic trip_c_o,
	input wire logic trip_single_pole_o,
	input wire logic trip_three_pole_o,
	input wire logic pole_open_start_o,
	input wire logic force_three_pole_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_3p_all; trip_three_pole_o |-> trip_a_o && trip_b_o && trip_c_o; endproperty
	a_3p_all: assert property (p_3p_all) else $error("3p without all poles");
	property p_1p_one; trip_single_pole_o |-> !trip_three_pole_o && $onehot({trip_a_o, trip_b_o, trip_c_o}); endproperty
	a_1p_one: assert property (p_1p_one) else $error("1p pole set wrong");
	property p_pole; pole_open_start_o == (trip_single_pole_o && !trip_three_pole_o); endproperty
	a_pole: assert property (p_pole) else $error("pole open mismatch");
	property p_rip; reclose_in_progress_i [*2] |=> fault_type_o == 4'h0; endproperty
	a_rip: assert property (p_rip) else $error("selector live in reclose");
	property p_clr; trip_single_pole_o [*2] |-> fault_type_o == 4'h0; endproperty
	a_clr: assert property (p_clr) else $error("selector live after trip");
	property p_lock; !force_three_pole_o && $past(trip_single_pole_o) |-> !$rose(trip_three_pole_o); endproperty
	a_lock: assert property (p_lock) else $error("trip during lockout");
	property p_force; force_three_pole_o |-> !$rose(trip_single_pole_o); endproperty
	a_force: assert property (p_force) else $error("1p trip under force");
	property p_rdy; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("ready pulse wrong");
	c_1p: cover property (pole_open_start_o);
	c_3p: cover property (trip_three_pole_o && force_three_pole_o);
	c_rdy: cover property (pready_o);
endmodule // pft_trip_monitor
bind pft_trip pft_trip_monitor u_mon (.clk_i, .rst_b_i, .psel_i, .penable_i, .pready_o, .reclose_in_progress_i,
	.fault_type_o, .trip_a_o, .trip_b_o, .trip_c_o, .trip_single_pole_o, .trip_three_pole_o, .pole_open_start_o,
	.force_three_pole_o);
`default_nettype wire

//--- pft_remote_model.sv
// pft_remote_model: remote terminal keying the one-bit channel
`timescale 1ns/1ps
`default_nettype none
module pft_remote_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic blocking_i,
	input wire logic fault_i,
	output logic [3:0] rx_o
);
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) rx_o <= 4'h0;
		else rx_o <= {3'h0, fault_i ^ blocking_i};
	end
endmodule // pft_remote_model
`default_nettype wire

//--- pft_trip_tb.sv
// pft_trip_tb: self-checking testbench of the trip block
`timescale 1ns/1ps
`default_nettype none
module pft_trip_tb;
	import pft_pkg::*;
	localparam logic [4:0] CC [11] = '{5'h18, 5'h18, 5'h19, 5'h19, 5'h1a, 5'h1a, 5'h1c, 5'h1c, 5'h1d, 5'h18,
		5'h1e};
	localparam logic [3:0] CF [11] = '{FT_AG, FT_NONE, FT_AG, FT_NONE, FT_CG, FT_BG, FT_CG, FT_AB, FT_AG, FT_UNREC,
		FT_AG};
	localparam logic [3:0] CX [11] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h3, 4'h2, 4'h4, 4'h8, 4'he, 4'h1, 4'h0};
	logic clk_i = 1'h0;
	logic rst_b = 1'h0;
	logic psel = 1'h0;
	logic pen = 1'h0;
	logic pwr = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwd = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic perr;
	logic dd = 1'h0;
	logic rip = 1'h0;
	logic req = 1'h0;
	logic rf = 1'h0;
	logic blk = 1'h0;
	logic [3:0] cur = 4'h0;
	logic [3:0] vol = 4'h0;
	logic [3:0] rx;
	logic [3:0] tx;
	logic [3:0] ft;
	logic f3;
	wire logic [5:0] tr;
	int mismatches = 0;
	int samples_checked = 0;
	always #5 clk_i = ~clk_i;
	pft_trip #(.FORCE_3P_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
		.disturbance_detector_i(dd), .current_class_i(cur), .voltage_class_i(vol), .reclose_in_progress_i(rip),
		.local_trip_request_i(req), .receive_bits_i(rx), .transmit_bits_o(tx), .fault_type_o(ft),
		.trip_a_o(tr[5]), .trip_b_o(tr[4]), .trip_c_o(tr[3]), .trip_single_pole_o(tr[2]),
		.trip_three_pole_o(tr[1]), .pole_open_start_o(tr[0]), .force_three_pole_o(f3));
	pft_remote_model u_remote (.clk_i(clk_i), .rst_b_i(rst_b), .blocking_i(blk), .fault_i(rf), .rx_o(rx));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic rst();
		@(posedge clk_i);
		rst_b <= 1'h0;
		{dd, rip, req, rf, blk, cur, vol} <= 13'h0;
		cyc(2);
		rst_b <= 1'h1;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] er,
		input logic ee);
		int n;
		n = 0;
		@(posedge clk_i);
		{psel, pwr, paddr, pwd} <= {1'h1, w, a, d};
		@(posedge clk_i);
		pen <= 1'h1;
		// sample the answer at the rising edge that completes the access phase
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) mismatches++;
		if (!w) check(prdata, er);
		check({31'h0, perr}, {31'h0, ee});
		{psel, pen} <= 2'h0;
	endtask
	task automatic t_regs();
		rst();
		apb(1'h0, REG_CTRL, 32'h0, {27'h0, CTRL_RESET}, 1'h0);
		apb(1'h0, 12'h00c, 32'h0, 32'h0, 1'h1);
		apb(1'h1, REG_STATUS, 32'hff, 32'h0, 1'h1);
		$display("regs done");
	endtask
	task automatic t_codes();
		for (int i = 0; i < 11; i++) begin
			rst();
			apb(1'h1, REG_CTRL, {27'h0, CC[i]}, 32'h0, 1'h0);
			blk <= CC[i][0];
			dd <= (CF[i] != FT_NONE);
			cur <= CF[i];
			vol <= CF[i];
			cyc(4);
			check(tx, CX[i]);
			check(ft, CF[i]);
		end
		$display("codes done");
	endtask
	task automatic t_1p();
		int n;
		rst();
		{rf, dd, cur, vol} <= {2'h3, FT_AG, FT_AG};
		cyc(2);
		req <= 1'h1;
		cyc(3);
		check(tr, 6'h25);
		{rip, req, cur, vol} <= {2'h2, FT_BG, FT_BG};
		cyc(3);
		check(ft, FT_NONE);
		req <= 1'h1;
		cyc(3);
		check(tr, 6'h0);
		for (n = 0; n < 40 && f3 !== 1'h1; n++) @(posedge clk_i);
		check(f3, 1'h1);
		cyc(3);
		check(tr, 6'h3a);
		$display("single pole done");
	endtask
	task automatic t_3p();
		logic [3:0] tc [3] = '{FT_ABG, FT_UNREC, FT_UNREC};
		logic [3:0] tv [3] = '{FT_ABG, FT_UNREC, FT_BG};
		logic [5:0] te [3] = '{6'h3a, 6'h3a, 6'h15};
		for (int i = 0; i < 3; i++) begin
			rst();
			{rf, dd, cur, vol} <= {2'h3, tc[i], tv[i]};
			cyc(3);
			check(ft, (i == 2) ? FT_BG : tc[i]);
			req <= 1'h1;
			cyc(3);
			check(tr, te[i]);
		end
		$display("three pole done");
	endtask
	task automatic test_done();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		t_regs();
		t_codes();
		t_1p();
		t_3p();
		test_done();
	end
	initial begin
		#200000;
		mismatches++;
		test_done();
	end
endmodule // pft_trip_tb
`default_nettype wire
